// File: design/ppr_router.v
/*
 * Peripheral pin router: APB register file plus the input and output
 * routing fabric between peripherals and the 32 possible pin positions.
 * Assumes pins are presented as a 5-bit code space (port*8 + bit), the
 * pad ring applies output data/enable, and analog paths bypass this block.
 */
module ppr_router (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  // Pin side, indexed by pin code
  input  wire [31:0]            pin_in,
  output reg  [31:0]            pin_out,
  output reg  [31:0]            pin_oe,
  // Peripheral outputs, indexed by source code (code 0 unused)
  input  wire [31:0]            periph_out,
  // Bidirectional peripheral overrides, indexed by source code
  input  wire [31:0]            periph_ovr,
  input  wire [31:0]            periph_oe,
  // Peripheral inputs
  output reg  [19:0]            periph_in
);

`include "ppr_defs.vh"

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg                      route_lock_flag;
  reg  [`PPR_IN_W-1:0]     input_route_select  [0:`PPR_N_IN-1];
  reg  [`PPR_OUT_W-1:0]    output_route_select [0:31];
  reg  [31:0]              pin_direction_bit;   // 1 = input, driver off
  reg  [31:0]              port_latch;
  reg  [31:0]              next_pin_out;
  reg  [31:0]              next_pin_oe;
  reg  [19:0]              next_periph_in;
  reg  [31:0]              rd_word;
  reg                      rd_hit;
  integer                  i;

  // Pin code to valid-position check: 18 real pins (A0-A5, B4-B7, C0-C7)
  function pin_exists;
    input [4:0] code;
    begin
      case (code[4:3])
        2'b00:   pin_exists = (code[2:0] <= 3'h5);
        2'b01:   pin_exists = (code[2:0] >= 3'h4);
        2'b10:   pin_exists = 1'b1;
        default: pin_exists = 1'b0;
      endcase
    end
  endfunction

  // Reset value of one input route register
  function [`PPR_IN_W-1:0] in_reset;
    input integer k;
    begin
      case (k)
        0:  in_reset = `PPR_RST_IN0;
        1:  in_reset = `PPR_RST_IN1;
        2:  in_reset = `PPR_RST_IN2;
        3:  in_reset = `PPR_RST_IN3;
        4:  in_reset = `PPR_RST_IN4;
        5:  in_reset = `PPR_RST_IN5;
        6:  in_reset = `PPR_RST_IN6;
        7:  in_reset = `PPR_RST_IN7;
        8:  in_reset = `PPR_RST_IN8;
        9:  in_reset = `PPR_RST_IN9;
        10: in_reset = `PPR_RST_IN10;
        11: in_reset = `PPR_RST_IN11;
        12: in_reset = `PPR_RST_IN12;
        13: in_reset = `PPR_RST_IN13;
        14: in_reset = `PPR_RST_IN14;
        15: in_reset = `PPR_RST_IN15;
        16: in_reset = `PPR_RST_IN16;
        17: in_reset = `PPR_RST_IN17;
        18: in_reset = `PPR_RST_IN18;
        default: in_reset = `PPR_RST_IN19;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // APB access: one wait state per access, write takes effect in the ready cycle
  // ----------------------------------------------------------------------
  wire acc    = psel & penable & ~pready;
  // Write lands at the edge where the master samples pready high
  wire wr     = psel & penable & pready & pwrite;
  wire in_hit = (paddr[11:8] == 4'h1) && (paddr[7:2] < `PPR_N_IN) && (paddr[1:0] == 2'b00);
  wire out_hit = (paddr[11:8] == 4'h2) && (paddr[1:0] == 2'b00)
                 && pin_exists(paddr[6:2]) && (paddr[7] == 1'b0);

  // Read mux; unimplemented upper bits read as zero
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == `PPR_OFF_LOCK)
      rd_word[`PPR_LOCK_BIT] = route_lock_flag;
    else if (in_hit)
      rd_word[`PPR_IN_W-1:0] = input_route_select[paddr[6:2]];
    else if (out_hit)
      rd_word[`PPR_OUT_W-1:0] = output_route_select[paddr[6:2]];
    else if (paddr == `PPR_OFF_DIR)
      rd_word = pin_direction_bit;
    else if (paddr == `PPR_OFF_LAT)
      rd_word = port_latch;
    else
      rd_hit = 1'b0;
  end

  // Bus handshake and register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      prdata            <= 32'h0000_0000;
      route_lock_flag   <= 1'b0;
      pin_direction_bit <= 32'hFFFF_FFFF;
      port_latch        <= 32'h0000_0000;
      for (i = 0; i < `PPR_N_IN; i = i + 1)
        input_route_select[i] <= in_reset(i);
      for (i = 0; i < 32; i = i + 1)
        output_route_select[i] <= `PPR_SRC_LATCH;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~rd_hit;
      prdata  <= (acc & ~pwrite) ? rd_word : 32'h0000_0000;
      if (wr) begin
        if (paddr == `PPR_OFF_LOCK)
          route_lock_flag <= pwdata[`PPR_LOCK_BIT];
        else if (paddr == `PPR_OFF_DIR)
          pin_direction_bit <= pwdata;
        else if (paddr == `PPR_OFF_LAT)
          port_latch <= pwdata;
        // Locked routing holds so a runaway write cannot reroute pins
        else if (in_hit && !route_lock_flag)
          input_route_select[paddr[6:2]] <= pwdata[`PPR_IN_W-1:0];
        else if (out_hit && !route_lock_flag)
          output_route_select[paddr[6:2]] <= pwdata[`PPR_OUT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Routing fabric; inputs and outputs use separate selections
  // ----------------------------------------------------------------------
  always @* begin
    next_periph_in = 20'h00000;
    for (i = 0; i < `PPR_N_IN; i = i + 1)
      // Code above 31 names no pin and feeds zero
      next_periph_in[i] = (input_route_select[i][5] == 1'b0)
                          && pin_in[input_route_select[i][4:0]];
    next_pin_out = 32'h0000_0000;
    next_pin_oe  = 32'h0000_0000;
    for (i = 0; i < 32; i = i + 1) begin
      if (pin_exists(i[4:0])) begin
        if (output_route_select[i] == `PPR_SRC_LATCH)
          next_pin_out[i] = port_latch[i];
        else
          next_pin_out[i] = periph_out[output_route_select[i]];
        // Bidirectional peripherals own the driver while active
        if (output_route_select[i] != `PPR_SRC_LATCH &&
            periph_ovr[output_route_select[i]])
          next_pin_oe[i] = periph_oe[output_route_select[i]];
        else
          next_pin_oe[i] = ~pin_direction_bit[i];
      end
    end
  end

  // Registered outputs, one cycle behind the selection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out   <= 32'h0000_0000;
      pin_oe    <= 32'h0000_0000;
      periph_in <= 20'h00000;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      periph_in <= next_periph_in;
    end
  end

endmodule

// File: design/ppr_defs.vh
/*
 * Constants of the peripheral pin router: register offsets, field widths,
 * reset codes and source codes.
 * Assumes byte addressing on a 32-bit APB bus, one register per word.
 */
`ifndef PPR_DEFS_VH
`define PPR_DEFS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define PPR_N_IN        20
`define PPR_N_PIN       18
`define PPR_N_SRC       32
`define PPR_IN_W        6
`define PPR_OUT_W       5
`define PPR_CODE_W      5

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define PPR_OFF_LOCK    12'h000
`define PPR_OFF_IN_BASE 12'h100
`define PPR_OFF_OUT_BASE 12'h200
`define PPR_OFF_DIR     12'h300
`define PPR_OFF_LAT     12'h304
`define PPR_LOCK_BIT    0

// ----------------------------------------------------------------------
// Source code 0 drives the pin from its port latch
// ----------------------------------------------------------------------
`define PPR_SRC_LATCH   5'h00

// ----------------------------------------------------------------------
// Input route reset codes, in input index order
// ----------------------------------------------------------------------
`define PPR_RST_IN0  6'h02
`define PPR_RST_IN1  6'h02
`define PPR_RST_IN2  6'h05
`define PPR_RST_IN3  6'h04
`define PPR_RST_IN4  6'h05
`define PPR_RST_IN5  6'h15
`define PPR_RST_IN6  6'h13
`define PPR_RST_IN7  6'h02
`define PPR_RST_IN8  6'h10
`define PPR_RST_IN9  6'h11
`define PPR_RST_IN10 6'h13
`define PPR_RST_IN11 6'h15
`define PPR_RST_IN12 6'h14
`define PPR_RST_IN13 6'h13
`define PPR_RST_IN14 6'h14
`define PPR_RST_IN15 6'h11
`define PPR_RST_IN16 6'h05
`define PPR_RST_IN17 6'h11
`define PPR_RST_IN18 6'h10
`define PPR_RST_IN19 6'h12

`endif

// File: testbench/ppr_router_monitor.sv
/* Checker for the router's bus handshake and register read fields.
   Sees the router's ports only; bound to every router instance. */
module ppr_router_monitor (
  // Clock, reset and bus
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pin and peripheral side
  input wire [31:0] pin_in,
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe,
  input wire [31:0] periph_out,
  input wire [31:0] periph_ovr,
  input wire [31:0] periph_oe,
  input wire [19:0] periph_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read answer qualifier; a write answer carries no data
  wire rd = pready && !pwrite;
  property p_taken; psel && penable && !pready |=> pready; endproperty
  a_taken: assert property (p_taken) else $error("no answer one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held past one cycle");
  property p_quiet; !(psel && penable) |=> !pready; endproperty
  a_quiet: assert property (p_quiet) else $error("ready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error outside answer cycle");
  property p_map; pready && paddr[11:8] == 4'h1 && paddr[7:0] < 8'h50 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("error on input route register");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_in; rd && paddr[11:8] == 4'h1 |-> prdata[31:6] == 26'h0; endproperty
  a_in: assert property (p_in) else $error("input route upper bits set");
  property p_out; rd && paddr[11:8] == 4'h2 |-> prdata[31:5] == 27'h0; endproperty
  a_out: assert property (p_out) else $error("output route upper bits set");
  property p_lock; rd && paddr == 12'h000 |-> prdata[31:1] == 31'h0; endproperty
  a_lock: assert property (p_lock) else $error("lock upper bits set");
endmodule
bind ppr_router ppr_router_monitor i_mon (.*);

// File: testbench/ppr_pad_model.sv
/* Pad ring model: a pin shows the router's level while enabled,
   otherwise the level the outside world applies. */
module ppr_pad_model (
  // Router side
  input  wire [31:0] pin_out,
  input  wire [31:0] pin_oe,
  // Outside world and resolved pin
  input  wire [31:0] ext_level,
  output wire [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven bits win, so routed outputs loop back as real pads do
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// File: testbench/ppr_router_tb.sv
/* Self-checking bench for the pin router: reset, routing, lock.
   Assumes the pad model closes the loop from pin outputs to inputs. */
module ppr_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
`include "ppr_defs.vh"
  // ----------------------------------------
  // Signals, clock, instances
  // ----------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, pin_in, pin_out, pin_oe, ext = 0, r;
  logic [31:0] periph_out = 0, periph_ovr = 0, periph_oe = 0;
  logic [19:0] periph_in;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  always #10 pclk = ~pclk;
  ppr_router i_dut (.*);
  ppr_pad_model i_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset;
    logic [5:0] dflt [20] = '{6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h15, 6'h13, 6'h02, 6'h10,
      6'h11, 6'h13, 6'h15, 6'h14, 6'h13, 6'h14, 6'h11, 6'h05, 6'h11, 6'h10, 6'h12};
    xfer(0, `PPR_OFF_LOCK, 0);
    chk(r, 32'h0);
    for (int k = 0; k < 20; k++) begin
      xfer(0, 12'(12'h100 + 4 * k), 0);
      chk(r, {26'h0, dflt[k]});
    end
    xfer(0, 12'h204, 0);
    chk(r, 32'h0);
    xfer(0, 12'h008, 0);
    chk({31'h0, e}, 32'h1);
  endtask
  // Two inputs share one pin code: port C bit 5
  task automatic t_input;
    xfer(1, 12'h100, 32'hFFFF_FFD5);
    xfer(1, 12'h14C, 32'h15);
    xfer(0, 12'h100, 0);
    chk(r, 32'h15);
    ext <= 32'h0020_0000;
    repeat (2) @(posedge pclk);
    chk({30'h0, periph_in[19], periph_in[0]}, 32'h3);
    ext <= 32'h0;
    repeat (2) @(posedge pclk);
    chk({30'h0, periph_in[19], periph_in[0]}, 32'h0);
  endtask
  task automatic t_output;
    xfer(1, `PPR_OFF_LAT, 32'h2);
    xfer(1, `PPR_OFF_DIR, 32'hFFFF_FFFD);
    repeat (2) @(posedge pclk);
    chk(pin_out & pin_oe & 32'h2, 32'h2);
    xfer(1, 12'h204, 32'hE3);
    xfer(0, 12'h204, 0);
    chk(r, 32'h3);
    xfer(0, 12'h100, 0);
    chk(r, 32'h15);
    repeat (2) @(posedge pclk);
    chk({30'h0, pin_out[1], pin_oe[1]}, 32'h1);
    periph_out <= 32'h8;
    repeat (2) @(posedge pclk);
    chk({30'h0, pin_out[1], pin_oe[1]}, 32'h3);
    periph_ovr <= 32'h8;
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_oe[1]}, 32'h0);
    periph_oe <= 32'h8;
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_oe[1]}, 32'h1);
    periph_ovr <= 32'h0;
    xfer(1, `PPR_OFF_DIR, 32'hFFFF_FFFF);
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_oe[1]}, 32'h0);
  endtask
  task automatic t_lock;
    xfer(1, `PPR_OFF_LOCK, 32'h1);
    xfer(1, 12'h100, 32'h2);
    xfer(1, 12'h204, 32'h0);
    xfer(0, 12'h100, 0);
    chk(r, 32'h15);
    xfer(0, 12'h204, 0);
    chk(r, 32'h3);
    xfer(1, `PPR_OFF_LOCK, 32'h0);
    xfer(1, 12'h100, 32'h2);
    xfer(0, 12'h100, 0);
    chk(r, 32'h2);
  endtask
  // ----------------------------------------
  // Sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_input;
    t_output;
    t_lock;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end
endmodule
